/* hw/dlc_consts.vh */
`ifndef DLC_CONSTS_VH
`define DLC_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define DLC_IDX_DECEL 8'h8C
`define DLC_IDX_LOOP 8'h8E
`define DLC_ADDR_DECEL 12'h230
`define DLC_ADDR_LOOP 12'h238
`define DLC_RESET_VALUE 32'h00000000

// ----------------------------------------------------------------------
// Field positions of the fast deceleration register
// ----------------------------------------------------------------------
`define DLC_PARITY_BIT 31
`define DLC_BLANK_BIT 19
`define DLC_WIN_HI 18
`define DLC_WIN_LO 16
`define DLC_THR_HI 15
`define DLC_THR_LO 13
`define DLC_LOW_HI 12
`define DLC_LOW_LO 9
`define DLC_TAPER_BIT 8
`define DLC_EN_BIT 7
`define DLC_UP_HI 6
`define DLC_UP_LO 3
`define DLC_EXIT_HI 2
`define DLC_EXIT_LO 0
`define DLC_DECEL_WMASK 32'h800FFFFF

// ----------------------------------------------------------------------
// Field positions of the loop register
// ----------------------------------------------------------------------
`define DLC_KP_HI 29
`define DLC_KP_LO 20
`define DLC_KI_HI 19
`define DLC_KI_LO 8
`define DLC_CEIL_HI 7
`define DLC_CEIL_LO 5
`define DLC_FLOOR_HI 4
`define DLC_FLOOR_LO 2
`define DLC_MODE_HI 1
`define DLC_MODE_LO 0
`define DLC_LOOP_WMASK 32'hBFFFFFFF

// ----------------------------------------------------------------------
// Mode codes and scale constants
// ----------------------------------------------------------------------
`define DLC_MODE_OFF 2'h0
`define DLC_MODE_SPEED 2'h1
`define DLC_MODE_POWER 2'h2
`define DLC_KP_DIVISOR 10000
`define DLC_KI_DIVISOR 1000000
`define DLC_MV_PER_CODE 100

`endif

/* hw/dlc_pct_decode.v */
`timescale 1ns/10ps

// Converts three-bit percentage codes to tenths of a percent.
module dlc_pct_decode (
    // Codes
    input wire [2:0] window_code,
    input wire [2:0] threshold_code,
    input wire [2:0] exit_code,
    // Values in tenths of a percent
    output reg [9:0] window_pmil,
    output reg [9:0] threshold_pmil,
    output reg [9:0] exit_pmil
);

    // Low band: 0, 2.5, 5, 7.5, 10, 15, 20, 25 percent.
    function [9:0] low_band;
        input [2:0] code;
        begin
            case (code)
                3'h0: low_band = 10'h000;
                3'h1: low_band = 10'h019;
                3'h2: low_band = 10'h032;
                3'h3: low_band = 10'h04B;
                3'h4: low_band = 10'h064;
                3'h5: low_band = 10'h096;
                3'h6: low_band = 10'h0C8;
                default: low_band = 10'h0FA;
            endcase
        end
    endfunction

    always @* begin
        window_pmil = low_band(window_code);
        // Each code step removes 50 tenths, built as 32 + 16 + 2 times the code.
        threshold_pmil = 10'h3E8 - {2'h0, threshold_code, 5'h00} - {3'h0, threshold_code, 4'h0}
            - {6'h00, threshold_code, 1'b0};
        case (exit_code)
            3'h0: exit_pmil = 10'h005;
            3'h1: exit_pmil = 10'h00A;
            3'h2: exit_pmil = 10'h00F;
            3'h3: exit_pmil = 10'h014;
            3'h4: exit_pmil = 10'h019;
            3'h5: exit_pmil = 10'h01E;
            3'h6: exit_pmil = 10'h028;
            default: exit_pmil = 10'h032;
        endcase
    end

endmodule

/* hw/dlc_regs.v */
`timescale 1ns/10ps
`include "dlc_consts.vh"

// Contract
// - Comparator blanking during fast deceleration follows the blanking enable bit.
// - Duty window codes 0..7 give 0, 2.5, 5, 7.5, 10, 15, 20, 25 percent.
// - Duty threshold codes 0..7 give 100 down to 65 percent in 5 percent steps.
// - Lower current limit code n gives n times 0.1 V, code 0 reserved.
// - The taper bit lets the current limit fall progressively during deceleration.
// - Fast deceleration runs only while its enable bit is one.
// - Upper current limit code n gives n times 0.1 V, code 0 reserved.
// - Exit margin codes 0..7 give 0.5, 1, 1.5, 2, 2.5, 3, 4, 5 percent.
// - Proportional gain is the ten-bit field over 10000.
// - Integral gain is the twelve-bit field over one million.
// - Loop output ceiling codes 0..7 give 100 down to 65 percent.
// - Loop output floor codes 0..7 give 0, 2.5, 5, 7.5, 10, 15, 20, 25 percent.
// - Mode 0 disables the loop, 1 regulates speed, 2 power, 3 is reserved.
module dlc_regs (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Motor control status
    input wire decel_request,
    // Fast deceleration controls
    output reg rapid_slowdown_active,
    output reg comparator_blank,
    output reg decel_current_taper_active,
    output reg [9:0] decel_duty_window_pmil,
    output reg [9:0] decel_duty_threshold_pmil,
    output reg [9:0] decel_exit_margin_pmil,
    output reg [10:0] decel_current_lower_mv,
    output reg [10:0] decel_current_upper_mv,
    output reg decel_limit_invalid,
    // Loop controls
    output reg loop_enable,
    output reg loop_speed_mode,
    output reg loop_power_mode,
    output reg loop_mode_invalid,
    output reg [9:0] loop_proportional_gain,
    output reg [11:0] loop_integral_gain,
    output reg [9:0] loop_output_ceiling_pmil,
    output reg [9:0] loop_output_floor_pmil
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    reg [31:0] fast_decel_config;
    reg [31:0] speed_power_loop_config;
    reg decel_req_meta;
    reg decel_req_sync;

    wire hit_decel = (paddr == `DLC_ADDR_DECEL);
    wire hit_loop = (paddr == `DLC_ADDR_LOOP);
    wire access = psel & penable;

    assign pready = 1'b1;
    assign pslverr = access & ~hit_decel & ~hit_loop;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_decel_config <= `DLC_RESET_VALUE;
            speed_power_loop_config <= `DLC_RESET_VALUE;
        end else if (access && pwrite) begin
            if (hit_decel) begin
                fast_decel_config <= pwdata & `DLC_DECEL_WMASK;
            end
            if (hit_loop) begin
                speed_power_loop_config <= pwdata & `DLC_LOOP_WMASK;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (hit_decel) begin
                prdata <= fast_decel_config;
            end else if (hit_loop) begin
                prdata <= speed_power_loop_config;
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request synchroniser
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            decel_req_meta <= 1'b0;
            decel_req_sync <= 1'b0;
        end else begin
            decel_req_meta <= decel_request;
            decel_req_sync <= decel_req_meta;
        end
    end

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire [9:0] win_pmil;
    wire [9:0] thr_pmil;
    wire [9:0] exit_pmil;
    wire [9:0] ceil_pmil;
    wire [9:0] floor_pmil;

    dlc_pct_decode u_decel_pct (
        .window_code(fast_decel_config[`DLC_WIN_HI:`DLC_WIN_LO]),
        .threshold_code(fast_decel_config[`DLC_THR_HI:`DLC_THR_LO]),
        .exit_code(fast_decel_config[`DLC_EXIT_HI:`DLC_EXIT_LO]),
        .window_pmil(win_pmil),
        .threshold_pmil(thr_pmil),
        .exit_pmil(exit_pmil)
    );

    dlc_pct_decode u_loop_pct (
        .window_code(speed_power_loop_config[`DLC_FLOOR_HI:`DLC_FLOOR_LO]),
        .threshold_code(speed_power_loop_config[`DLC_CEIL_HI:`DLC_CEIL_LO]),
        .exit_code(3'h0),
        .window_pmil(floor_pmil),
        .threshold_pmil(ceil_pmil),
        .exit_pmil()
    );

    // Current limit code to millivolts at the sense amplifier output.
    function [10:0] limit_mv;
        input [3:0] code;
        begin
            limit_mv = code * 7'd`DLC_MV_PER_CODE;
        end
    endfunction

    wire en = fast_decel_config[`DLC_EN_BIT];
    wire active = en & decel_req_sync;
    wire [3:0] low_code = fast_decel_config[`DLC_LOW_HI:`DLC_LOW_LO];
    wire [3:0] up_code = fast_decel_config[`DLC_UP_HI:`DLC_UP_LO];
    wire [1:0] mode = speed_power_loop_config[`DLC_MODE_HI:`DLC_MODE_LO];

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rapid_slowdown_active <= 1'b0;
            comparator_blank <= 1'b0;
            decel_current_taper_active <= 1'b0;
            decel_duty_window_pmil <= 10'h000;
            decel_duty_threshold_pmil <= 10'h3E8;
            decel_exit_margin_pmil <= 10'h005;
            decel_current_lower_mv <= 11'h000;
            decel_current_upper_mv <= 11'h000;
            decel_limit_invalid <= 1'b0;
            loop_enable <= 1'b0;
            loop_speed_mode <= 1'b0;
            loop_power_mode <= 1'b0;
            loop_mode_invalid <= 1'b0;
            loop_proportional_gain <= 10'h000;
            loop_integral_gain <= 12'h000;
            loop_output_ceiling_pmil <= 10'h3E8;
            loop_output_floor_pmil <= 10'h000;
        end else begin
            rapid_slowdown_active <= active;
            comparator_blank <= active & fast_decel_config[`DLC_BLANK_BIT];
            decel_current_taper_active <= active & fast_decel_config[`DLC_TAPER_BIT];
            decel_duty_window_pmil <= win_pmil;
            decel_duty_threshold_pmil <= thr_pmil;
            decel_exit_margin_pmil <= exit_pmil;
            decel_current_lower_mv <= limit_mv(low_code);
            decel_current_upper_mv <= limit_mv(up_code);
            decel_limit_invalid <= en & ((low_code == 4'h0) | (up_code == 4'h0));
            loop_enable <= (mode == `DLC_MODE_SPEED) | (mode == `DLC_MODE_POWER);
            loop_speed_mode <= (mode == `DLC_MODE_SPEED);
            loop_power_mode <= (mode == `DLC_MODE_POWER);
            loop_mode_invalid <= (mode == 2'h3);
            loop_proportional_gain <= speed_power_loop_config[`DLC_KP_HI:`DLC_KP_LO];
            loop_integral_gain <= speed_power_loop_config[`DLC_KI_HI:`DLC_KI_LO];
            loop_output_ceiling_pmil <= ceil_pmil;
            loop_output_floor_pmil <= floor_pmil;
        end
    end

endmodule

/* verification/dlc_regs_asserts.sv */
`timescale 1ns/10ps

module dlc_regs_asserts (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    // Controls
    input wire decel_request,
    input wire rapid_slowdown_active,
    input wire comparator_blank,
    input wire decel_current_taper_active,
    input wire [9:0] decel_duty_window_pmil,
    input wire [9:0] decel_duty_threshold_pmil,
    input wire [9:0] decel_exit_margin_pmil,
    input wire [10:0] decel_current_lower_mv,
    input wire [10:0] decel_current_upper_mv,
    input wire loop_speed_mode,
    input wire loop_power_mode,
    input wire [9:0] loop_proportional_gain,
    input wire [11:0] loop_integral_gain,
    input wire [9:0] loop_output_ceiling_pmil,
    input wire [9:0] loop_output_floor_pmil
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire wr_decel = psel && penable && pwrite && paddr == 12'h230;
    wire wr_loop = psel && penable && pwrite && paddr == 12'h238;

    AST_BLANK_ACTIVE: assert property (comparator_blank |-> rapid_slowdown_active
        || $past(rapid_slowdown_active)) else $error("blanking without deceleration");
    AST_WINDOW: assert property (decel_duty_window_pmil inside
        {0, 25, 50, 75, 100, 150, 200, 250}) else $error("bad duty window");
    AST_THRESHOLD: assert property (decel_duty_threshold_pmil inside
        {1000, 950, 900, 850, 800, 750, 700, 650}) else $error("bad duty threshold");
    AST_LOWER_LIMIT: assert property (wr_decel |-> ##2
        decel_current_lower_mv == 11'd100 * $past(pwdata[12:9], 2)) else $error("bad limit");
    AST_TAPER_ACTIVE: assert property (decel_current_taper_active |->
        rapid_slowdown_active) else $error("taper without deceleration");
    AST_NO_REQUEST: assert property (!$past(decel_request, 2) && !$past(decel_request, 3)
        && !$past(decel_request, 4) |-> !rapid_slowdown_active) else $error("slowdown w/o request");
    AST_UPPER_LIMIT: assert property (wr_decel |-> ##2
        decel_current_upper_mv == 11'd100 * $past(pwdata[6:3], 2)) else $error("bad upper limit");
    AST_EXIT: assert property (decel_exit_margin_pmil inside
        {5, 10, 15, 20, 25, 30, 40, 50}) else $error("bad exit margin");
    AST_KP: assert property (wr_loop |-> ##2
        loop_proportional_gain == $past(pwdata[29:20], 2)) else $error("bad proportional gain");
    AST_KI: assert property (wr_loop |-> ##2
        loop_integral_gain == $past(pwdata[19:8], 2)) else $error("bad integral gain");
    AST_CEILING: assert property (loop_output_ceiling_pmil inside
        {1000, 950, 900, 850, 800, 750, 700, 650}) else $error("bad ceiling");
    AST_FLOOR: assert property (loop_output_floor_pmil inside
        {0, 25, 50, 75, 100, 150, 200, 250}) else $error("bad floor");
    AST_MODE: assert property (wr_loop |-> ##2 {loop_speed_mode, loop_power_mode} ==
        {$past(pwdata[1:0], 2) == 2'h1, $past(pwdata[1:0], 2) == 2'h2}) else $error("bad mode");
endmodule

bind dlc_regs dlc_regs_asserts u_dlc_regs_asserts (.*);

/* verification/dlc_regs_test.sv */
`timescale 1ns/10ps
`include "dlc_consts.vh"

module dlc_regs_test;
    reg clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, decel_request = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    reg err;
    wire pready, pslverr, act, blank, taper, linv, len, lspd, lpwr, linval;
    wire [31:0] prdata;
    wire [9:0] win_o, thr_o, exit_o, kp_o, ceil_o, flr_o;
    wire [10:0] low_o, up_o;
    wire [11:0] ki_o;
    int fail_count = 0, n_compared = 0;
    int pct[8] = '{0, 25, 50, 75, 100, 150, 200, 250};
    int exm[8] = '{5, 10, 15, 20, 25, 30, 40, 50};
    always #10 clk = ~clk;
    dlc_regs u_dlc_regs (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .decel_request(decel_request), .rapid_slowdown_active(act),
        .comparator_blank(blank), .decel_current_taper_active(taper),
        .decel_duty_window_pmil(win_o), .decel_duty_threshold_pmil(thr_o),
        .decel_exit_margin_pmil(exit_o), .decel_current_lower_mv(low_o),
        .decel_current_upper_mv(up_o), .decel_limit_invalid(linv), .loop_enable(len),
        .loop_speed_mode(lspd), .loop_power_mode(lpwr), .loop_mode_invalid(linval),
        .loop_proportional_gain(kp_o), .loop_integral_gain(ki_o),
        .loop_output_ceiling_pmil(ceil_o), .loop_output_floor_pmil(flr_o));

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task test_reset;
        chk("ready", pready, 1);
        chk("threshold", thr_o, 1000);
        chk("exit", exit_o, 5);
        chk("ceiling", ceil_o, 1000);
        chk("active", act, 0);
        apb(0, `DLC_ADDR_DECEL, 0);
        chk("decel reset", rd, `DLC_RESET_VALUE);
        apb(0, `DLC_ADDR_LOOP, 0);
        chk("loop reset", rd, `DLC_RESET_VALUE);
        $display("test_reset done");
    endtask

    task test_decel_fields;
        logic [31:0] d;
        for (int c = 0; c < 8; c++) begin
            d = {12'h800, 1'b0, 3'(c), 3'(c), 4'(2 * c + 1), 2'b01, 4'(7 - c), 3'(c)};
            apb(1, `DLC_ADDR_DECEL, d);
            apb(0, `DLC_ADDR_DECEL, 0);
            chk("decel readback", rd, d & `DLC_DECEL_WMASK);
            chk("window", win_o, pct[c]);
            chk("threshold", thr_o, 1000 - 50 * c);
            chk("lower", low_o, 100 * (2 * c + 1));
            chk("upper", up_o, 100 * (7 - c));
            chk("exit", exit_o, exm[c]);
            chk("limit invalid", linv, c == 7);
        end
        $display("test_decel_fields done");
    endtask

    task test_loop_fields;
        logic [31:0] d;
        for (int c = 0; c < 8; c++) begin
            d = {2'b10, 10'(1023 - 100 * c), 12'(4095 - 500 * c),
                3'(c), 3'(7 - c), 2'(c)};
            apb(1, `DLC_ADDR_LOOP, d);
            apb(0, `DLC_ADDR_LOOP, 0);
            chk("loop readback", rd, d & `DLC_LOOP_WMASK);
            chk("kp", kp_o, 1023 - 100 * c);
            chk("ki", ki_o, 4095 - 500 * c);
            chk("ceiling", ceil_o, 1000 - 50 * c);
            chk("floor", flr_o, pct[7 - c]);
            chk("mode", {lspd, lpwr, linval}, {c % 4 == 1, c % 4 == 2, c % 4 == 3});
            if (c % 4 != 3) chk("loop enable", len, c % 4 != 0);
        end
        $display("test_loop_fields done");
    endtask

    task test_slowdown;
        apb(1, `DLC_ADDR_DECEL, 32'h000809F9);
        decel_request <= 1;
        settle(5);
        chk("active", act, 1);
        chk("blank", blank, 1);
        chk("taper", taper, 1);
        apb(1, `DLC_ADDR_DECEL, 32'h00000278);
        settle(3);
        chk("disabled", act, 0);
        apb(1, `DLC_ADDR_DECEL, 32'h000002F8);
        settle(3);
        chk("active plain", act, 1);
        chk("no blank", blank, 0);
        chk("no taper", taper, 0);
        @(posedge clk);
        decel_request <= 0;
        settle(5);
        chk("released", act, 0);
        $display("test_slowdown done");
    endtask

    task test_unmapped;
        apb(1, 12'h234, 32'hFFFFFFFF);
        chk("write error", err, 1);
        apb(0, 12'h234, 0);
        chk("read error", err, 1);
        chk("read zero", rd, 0);
        apb(0, `DLC_ADDR_LOOP, 0);
        chk("mapped ok", err, 0);
        $display("test_unmapped done");
    endtask

    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        end_of_test;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        settle(1);
        test_reset;
        test_decel_fields;
        test_loop_fields;
        test_slowdown;
        test_unmapped;
        end_of_test;
    end
endmodule
